// >>> shared/smp_pkg.sv
// constants, carriers and state types of the servo motion-profile positioner
// assumes a 25 MHz core clock and a 1 ms profile tick derived from it
package smp_pkg;
	// ********
	// timing
	// ********
	localparam int CLK_NS          = 40;
	localparam int TICK_NS         = 1000000;
	localparam int TICK_CYC        = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int PAUSE_UNIT_MS   = 100;
	localparam int WT_RUN_MS       = 500;
	// ********
	// scaling
	// ********
	localparam int STEPS_PER_REV   = 4096;
	localparam int FRAC_W          = 16;
	// steps per ms per rpm in q16: 4096 * 65536 / 60000
	localparam logic [31:0] VEL_PER_RPM = 32'h0000117a;
	// q16 steps per ms gained per ms over one 1000 rpm ramp of 1 ms
	localparam logic [31:0] DV_NUM      = 32'h00444444;
	localparam logic [31:0] VEL_MIN     = 32'h00010000;
	localparam int FF_MUL          = 15;
	localparam int GAIN_SHIFT      = 6;
	localparam logic [15:0] WT_RPM      = 16'h0032;
	localparam logic [31:0] WT_MIN_MOVE = 32'h00000100;
	// ********
	// wiring test codes, info selector and test start point codes
	// ********
	localparam logic [7:0] WT_OK        = 8'h00;
	localparam logic [7:0] WT_ENABLE    = 8'h01;
	localparam logic [7:0] WT_DIR       = 8'h02;
	localparam logic [7:0] WT_POLES     = 8'h03;
	localparam logic [7:0] WT_RES_PHASE = 8'h04;
	localparam logic [7:0] WT_SETTING   = 8'h05;
	localparam logic [7:0] WT_ABORT     = 8'h63;
	localparam logic [15:0] INFO_WT     = 16'h0000;
	localparam logic [15:0] INFO_POS    = 16'h0001;
	localparam logic [15:0] INFO_REF    = 16'h0002;
	localparam logic [15:0] INFO_VIB    = 16'h0003;
	localparam logic [15:0] INFO_DEV    = 16'h0004;
	localparam logic [15:0] SP_HALF     = 16'h0002;
	localparam logic [15:0] SP_NEG      = 16'h0003;
	// ********
	// carriers
	// ********
	typedef struct packed {
		logic [15:0] manual_speed_or_pulse_k_factor;
		logic [15:0] profile_speed_or_accel_time;
		logic [15:0] stroke_or_steady_speed;
		logic [15:0] test_start_point;
		logic [15:0] reversal_pause;
		logic [15:0] info_value_or_error_window;
		logic [15:0] info_select_or_position_gain;
		logic signed [15:0] feedback_multiplier;
		logic signed [15:0] feedback_divider;
	} smp_params_s;
	localparam smp_params_s PARAM_DEFAULTS = '{16'h0064, 16'h03e8,
		16'h001e, 16'h0001, 16'h0001, 16'h0064, 16'h0000, 16'sh0001,
		16'sh0001};
	typedef struct packed {
		logic test_profile_start;
		logic manual_fwd_or_feedback_select;
		logic manual_rev_or_incr_clear;
		logic wiring_test_cmd;
		logic move_direction;
		logic vibration_test_or_servo_error;
		logic feed_forward_enable;
		logic position_start_cmd;
		logic pulse_input_enable;
		logic reset_kind_one;
		logic reset_kind_two;
		logic reset_kind_three;
		logic run_precomputed_profile;
		logic profile_calc_cmd;
	} smp_cmd_s;
	typedef struct packed {
		logic        profile_running;
		logic        profile_calc_busy;
		logic        servo_error;
		logic        wiring_test_active;
		logic [31:0] position_loop_reference;
		logic [31:0] motor_position_steps;
		logic [31:0] incremental_position;
		logic [31:0] final_position;
		logic [31:0] vibration_accumulator;
		logic [31:0] deviation_index;
		logic [31:0] info_value;
	} smp_status_s;
	typedef enum logic [1:0] {PH_IDLE, PH_ACC, PH_CRUISE, PH_DEC} smp_ph_e;
	typedef enum logic [2:0] {TP_IDLE, TP_POS, TP_PAUSE_A, TP_NEG,
		TP_PAUSE_B} smp_tp_e;
endpackage : smp_pkg

// >>> design/smp_top.sv
// motion-profile logic: commissioning mode and trapezoidal positioner
// assumes parameters and command bits come from software on the same clock,
// resolver angle and encoder steps from decoders on the same clock;
// only the frequency input pin is asynchronous
// Function
// RULE1 - manual forward runs at manual speed
// RULE2 - manual reverse runs negative manual speed
// RULE3 - start point picks first leg
// RULE4 - test profile uses profile speed, stroke
// RULE5 - zero speed pause between legs
// RULE6 - info value follows info selector
// RULE7 - wiring test runs, then reports code
// RULE8 - operator unloads motor, sets enables first
// RULE9 - vibration accumulator grows, clearable
// RULE10 - start moves incremental steps, 4096/rev
// RULE11 - magnitude used, direction bit picks sense
// RULE12 - start delay varies with calculation
// RULE13 - running status while profile runs
// RULE14 - precalculate, then run jitter free
// RULE15 - software holds parameters during calculation
// RULE16 - sticky servo error beyond window
// RULE17 - pulses times k add to increment
// RULE18 - feedback select, encoder scaling
// RULE19 - clear incremental position command
// RULE20 - three reset kinds when idle
// RULE21 - final position updated on positioning
// RULE22 - proportional gain plus optional feed-forward
// RULE23 - ramp by accel time, cruise speed
// RULE24 - reference enable gates speed output
// RULE25 - wiring test error code values
// RULE26 - symmetric deceleration, exact stop
`timescale 1ns/1ps
module smp_top #(
	parameter int TICK_CYC = smp_pkg::TICK_CYC
) (
	input  wire logic                 core_clk,
	input  wire logic                 nrst,
	input  wire logic                 positioner_mode,
	input  wire smp_pkg::smp_params_s params,
	input  wire smp_pkg::smp_cmd_s    cmd,
	input  wire logic                 reserved_reference_enable,
	input  wire logic                 software_drive_enable,
	input  wire logic                 hardware_drive_enable,
	input  wire logic                 feedback_setting_nonzero,
	input  wire logic                 servo_error_clear,
	input  wire logic                 vibration_clear,
	input  wire logic                 incr_wr_en,
	input  wire logic [31:0]          incr_wr_data,
	input  wire logic                 frequency_input_connector,
	input  wire logic [11:0]          resolver_angle,
	input  wire logic                 encoder_step,
	input  wire logic                 encoder_dir,
	output logic signed [15:0]        speed_ref,
	output smp_pkg::smp_status_s      status
);
	// ********
	// state
	// ********
	typedef struct packed {
		logic [2:0]       fsync;
		smp_pkg::smp_cmd_s prev;
		logic [31:0]      tick_cnt;
		logic [11:0]      res_prev;
		logic [31:0]      res_acc;
		logic [31:0]      enc_raw;
		logic [31:0]      offset;
		logic [31:0]      ref_pos;
		logic [31:0]      start_ref;
		logic [31:0]      incr;
		logic [31:0]      final_pos;
		smp_pkg::smp_ph_e ph;
		logic [47:0]      moved_q;
		logic [31:0]      vel;
		logic [31:0]      vmax;
		logic [31:0]      dv;
		logic [31:0]      acc_dist;
		logic [31:0]      total;
		logic             dir;
		logic [31:0]      pend_dv;
		logic [31:0]      pend_vmax;
		logic [31:0]      pend_total;
		logic             pend_dir;
		logic             calc_busy;
		logic             go_after_calc;
		logic             servo_err;
		smp_pkg::smp_tp_e tp;
		logic [31:0]      pause_cnt;
		logic             wt_busy;
		logic [31:0]      wt_cnt;
		logic [31:0]      wt_start;
		logic [7:0]       wt_code;
		logic [31:0]      vib_acc;
		logic [31:0]      p1;
		logic [31:0]      p2;
		logic [31:0]      dev_idx;
		logic [15:0]      spd;
	} smp_state_s;

	smp_state_s st;
	smp_state_s next_st;
	logic [1:0] rst_sync;
	wire        rst_n = rst_sync[1];

	function automatic logic [31:0] abs32(input logic [31:0] v);
		abs32 = v[31] ? 32'(-v) : v;
	endfunction : abs32

	function automatic logic [15:0] sat16(input logic signed [47:0] v);
		if (v > 48'sh7fff)
			sat16 = 16'h7fff;
		else if (v < -48'sh8000)
			sat16 = 16'h8000;
		else
			sat16 = v[15:0];
	endfunction : sat16

	// ********
	// feedback and loop terms
	// ********
	logic signed [47:0] enc_scaled;
	logic signed [15:0] enc_div;
	logic        [31:0] motor_pos;
	logic        [31:0] pos_err;
	logic signed [47:0] loop_out;
	logic               tick;
	logic               fpulse;
	logic               tp_active;
	logic               man_active;

	always_comb begin
		enc_div = (params.feedback_divider == 16'sh0000) ? 16'sh0001 :
			params.feedback_divider;
		enc_scaled = 48'($signed(st.enc_raw) * params.feedback_multiplier)
			/ enc_div;                                          // RULE18
		motor_pos = (positioner_mode && cmd.manual_fwd_or_feedback_select)
			? 32'(enc_scaled) - st.offset
			: st.res_acc - st.offset;                           // RULE18
		pos_err = st.ref_pos - motor_pos;
		loop_out = 48'($signed(pos_err)) *
			$signed({1'b0, params.info_select_or_position_gain})
			>>> smp_pkg::GAIN_SHIFT;                            // RULE22
		if (cmd.feed_forward_enable)
			loop_out = loop_out + 48'($signed(st.dir ?
				-48'(st.vel * smp_pkg::FF_MUL >> smp_pkg::FRAC_W) :
				48'(st.vel * smp_pkg::FF_MUL >> smp_pkg::FRAC_W))); // RULE22
		tick = (st.tick_cnt == 32'(TICK_CYC - 1));
		// falling front, counted when stage 2 is still high and stage 1 has gone low
		fpulse = st.fsync[1] == 1'b0 && st.fsync[2] == 1'b1;
		tp_active = st.tp != smp_pkg::TP_IDLE;
		man_active = cmd.manual_fwd_or_feedback_select ||
			cmd.manual_rev_or_incr_clear;
	end

	// ********
	// next state
	// ********
	logic [31:0] moved;
	logic [31:0] mag;
	logic [31:0] leg;
	logic [31:0] d1;
	logic [31:0] d2;

	always_comb begin
		next_st = st;
		moved = st.moved_q[47:16];
		mag = abs32(st.incr);                                   // RULE11
		leg = 32'(params.stroke_or_steady_speed) *
			32'(smp_pkg::STEPS_PER_REV);                        // RULE4
		d1 = motor_pos - st.p1;
		d2 = st.p1 - st.p2;
		next_st.fsync = {st.fsync[1:0], frequency_input_connector};
		next_st.prev = cmd;
		next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;
		next_st.res_prev = resolver_angle;
		next_st.res_acc = st.res_acc +
			32'($signed(resolver_angle - st.res_prev));
		if (encoder_step)
			next_st.enc_raw = encoder_dir ? st.enc_raw - 32'h1 :
				st.enc_raw + 32'h1;
		if (servo_error_clear)
			next_st.servo_err = 1'b0;
		if (abs32(pos_err) > 32'(params.info_value_or_error_window) &&
			positioner_mode)
			next_st.servo_err = 1'b1;                           // RULE16
		if (vibration_clear)
			next_st.vib_acc = 32'h0;
		next_st.spd = 16'h0;
		if (positioner_mode) begin
			// incremental position: software, pulses, clear
			if (incr_wr_en)
				next_st.incr = incr_wr_data;
			if (cmd.pulse_input_enable && fpulse)
				next_st.incr = st.incr +
					32'(params.manual_speed_or_pulse_k_factor); // RULE17
			if (cmd.manual_rev_or_incr_clear)
				next_st.incr = 32'h0;                           // RULE19
			// calculation request: finishes on the next tick
			if ((cmd.profile_calc_cmd && !st.prev.profile_calc_cmd) ||
				(cmd.position_start_cmd && !st.prev.position_start_cmd)) begin
				next_st.calc_busy = 1'b1;                       // RULE14
				next_st.go_after_calc = cmd.position_start_cmd &&
					!st.prev.position_start_cmd;                // RULE12
			end
			if (st.calc_busy && tick) begin
				next_st.calc_busy = 1'b0;
				next_st.pend_dv = smp_pkg::DV_NUM /
					((params.profile_speed_or_accel_time == 16'h0) ? 32'h1 :
					32'(params.profile_speed_or_accel_time));   // RULE23
				next_st.pend_vmax = 32'(params.stroke_or_steady_speed) *
					smp_pkg::VEL_PER_RPM;                       // RULE23
				next_st.pend_total = mag;                       // RULE10
				next_st.pend_dir = cmd.move_direction;          // RULE11
			end
			if ((st.calc_busy && tick && st.go_after_calc) ||
				(cmd.run_precomputed_profile &&
				!st.prev.run_precomputed_profile && !st.calc_busy)) begin
				next_st.go_after_calc = 1'b0;
				next_st.dv = (st.calc_busy) ? next_st.pend_dv : st.pend_dv;
				next_st.vmax = (st.calc_busy) ? next_st.pend_vmax :
					st.pend_vmax;
				next_st.total = (st.calc_busy) ? mag : st.pend_total;
				next_st.dir = (st.calc_busy) ? cmd.move_direction :
					st.pend_dir;                                // RULE14
				next_st.start_ref = st.ref_pos;
				next_st.moved_q = 48'h0;
				next_st.vel = 32'h0;
				next_st.acc_dist = 32'h0;
				next_st.ph = smp_pkg::PH_ACC;                   // RULE13
				next_st.final_pos = next_st.dir ?
					st.ref_pos - next_st.total :
					st.ref_pos + next_st.total;                 // RULE21
			end else if (tick && st.ph != smp_pkg::PH_IDLE) begin
				next_st.moved_q = st.moved_q + 48'(st.vel);
				case (st.ph)
					smp_pkg::PH_ACC: begin
						next_st.vel = st.vel + st.dv;
						if (st.vel + st.dv >= st.vmax) begin
							next_st.vel = st.vmax;
							next_st.ph = smp_pkg::PH_CRUISE;
						end
						next_st.acc_dist = moved;
						if (moved >= (st.total >> 1))
							next_st.ph = smp_pkg::PH_DEC;       // RULE26
					end
					smp_pkg::PH_CRUISE: begin
						if (moved + st.acc_dist >= st.total)
							next_st.ph = smp_pkg::PH_DEC;       // RULE26
					end
					smp_pkg::PH_DEC: begin
						next_st.vel = (st.vel > st.dv + smp_pkg::VEL_MIN) ?
							st.vel - st.dv : smp_pkg::VEL_MIN;  // RULE26
					end
					default: next_st.ph = smp_pkg::PH_IDLE;
				endcase
				if (next_st.moved_q[47:16] >= st.total) begin
					next_st.moved_q = {st.total, 16'h0};
					next_st.vel = 32'h0;
					next_st.ph = smp_pkg::PH_IDLE;              // RULE26
				end
			end
			if (st.ph != smp_pkg::PH_IDLE)
				next_st.ref_pos = next_st.dir ?
					next_st.start_ref - next_st.moved_q[47:16] :
					next_st.start_ref + next_st.moved_q[47:16]; // RULE11
			else if (cmd.reset_kind_one && !st.prev.reset_kind_one) begin
				next_st.offset = motor_pos + st.offset;
				next_st.ref_pos = 32'h0;                        // RULE20
			end else if (cmd.reset_kind_two && !st.prev.reset_kind_two) begin
				next_st.offset = motor_pos + st.offset -
					32'(resolver_angle);
				next_st.ref_pos = 32'(resolver_angle);          // RULE20
			end else if (cmd.reset_kind_three &&
				!st.prev.reset_kind_three)
				next_st.ref_pos = motor_pos;                    // RULE20
			next_st.spd = sat16(loop_out);                      // RULE22
		end else begin
			// commissioning: wiring test
			if (cmd.wiring_test_cmd && !st.prev.wiring_test_cmd) begin
				next_st.wt_busy = 1'b1;
				next_st.wt_cnt = 32'h0;
				next_st.wt_start = motor_pos;
				if (software_drive_enable || !hardware_drive_enable) begin
					next_st.wt_busy = 1'b0;
					next_st.wt_code = smp_pkg::WT_ENABLE;       // RULE25
				end else if (feedback_setting_nonzero) begin
					next_st.wt_busy = 1'b0;
					next_st.wt_code = smp_pkg::WT_SETTING;      // RULE25
				end
			end else if (st.wt_busy) begin
				next_st.spd = smp_pkg::WT_RPM;                  // RULE7
				if (!cmd.wiring_test_cmd) begin
					next_st.wt_busy = 1'b0;
					next_st.wt_code = smp_pkg::WT_ABORT;        // RULE25
				end else if (tick) begin
					next_st.wt_cnt = st.wt_cnt + 32'h1;
					if (st.wt_cnt == 32'(smp_pkg::WT_RUN_MS)) begin
						next_st.wt_busy = 1'b0;
						next_st.spd = 16'h0;
						if ($signed(motor_pos - st.wt_start) < 0)
							next_st.wt_code = smp_pkg::WT_DIR;  // RULE25
						else if (motor_pos - st.wt_start <
							smp_pkg::WT_MIN_MOVE)
							next_st.wt_code = smp_pkg::WT_RES_PHASE;
						else
							next_st.wt_code = smp_pkg::WT_OK;   // RULE7
					end
				end
			end else if (cmd.test_profile_start) begin
				// test profile at constant profile speed
				if (tick && tp_active)
					next_st.moved_q = st.moved_q + 48'(st.vel);
				if (tick)
					next_st.dev_idx = st.dev_idx + abs32(pos_err);
				case (st.tp)
					smp_pkg::TP_IDLE: begin
						next_st.vel = 32'(params.profile_speed_or_accel_time)
							* smp_pkg::VEL_PER_RPM;             // RULE4
						next_st.moved_q = 48'h0;
						next_st.dev_idx = 32'h0;
						next_st.total = (params.test_start_point ==
							smp_pkg::SP_HALF) ? leg >> 1 : leg; // RULE3
						next_st.tp = (params.test_start_point ==
							smp_pkg::SP_NEG) ? smp_pkg::TP_NEG :
							smp_pkg::TP_POS;                    // RULE3
					end
					smp_pkg::TP_POS, smp_pkg::TP_NEG: begin
						next_st.spd = (st.tp == smp_pkg::TP_POS) ?
							params.profile_speed_or_accel_time :
							16'(-params.profile_speed_or_accel_time);
						if (moved >= st.total) begin
							next_st.moved_q = 48'h0;
							next_st.total = leg;
							next_st.pause_cnt = 32'h0;
							next_st.tp = (st.tp == smp_pkg::TP_POS) ?
								smp_pkg::TP_PAUSE_A : smp_pkg::TP_PAUSE_B;
						end
					end
					smp_pkg::TP_PAUSE_A, smp_pkg::TP_PAUSE_B: begin
						next_st.spd = 16'h0;                    // RULE5
						if (tick)
							next_st.pause_cnt = st.pause_cnt + 32'h1;
						if (st.pause_cnt >= 32'(params.reversal_pause) *
							32'(smp_pkg::PAUSE_UNIT_MS))
							next_st.tp = (st.tp == smp_pkg::TP_PAUSE_A) ?
								smp_pkg::TP_NEG : smp_pkg::TP_POS; // RULE5
					end
					default: next_st.tp = smp_pkg::TP_IDLE;
				endcase
			end else if (man_active) begin
				next_st.spd = cmd.manual_fwd_or_feedback_select ?
					params.manual_speed_or_pulse_k_factor :     // RULE1
					16'(-params.manual_speed_or_pulse_k_factor); // RULE2
			end else if (cmd.vibration_test_or_servo_error && tick) begin
				next_st.vib_acc = st.vib_acc + abs32(d1 - d2);  // RULE9
			end
			if (!cmd.test_profile_start)
				next_st.tp = smp_pkg::TP_IDLE;
			if (tick) begin
				next_st.p1 = motor_pos;
				next_st.p2 = st.p1;
			end
		end
		if (!reserved_reference_enable)
			next_st.spd = 16'h0;                                // RULE24
	end

	// ********
	// registers
	// ********
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	// ********
	// outputs
	// ********
	always_comb begin
		speed_ref = st.spd;
		status.profile_running = st.ph != smp_pkg::PH_IDLE;     // RULE13
		status.profile_calc_busy = st.calc_busy;
		status.servo_error = st.servo_err;                      // RULE16
		status.wiring_test_active = st.wt_busy;
		status.position_loop_reference = st.ref_pos;
		status.motor_position_steps = motor_pos;
		status.incremental_position = st.incr;
		status.final_position = st.final_pos;
		status.vibration_accumulator = st.vib_acc;
		status.deviation_index = st.dev_idx;
		case (params.info_select_or_position_gain)
			smp_pkg::INFO_WT:  status.info_value = 32'(st.wt_code); // RULE6
			smp_pkg::INFO_POS: status.info_value = motor_pos;
			smp_pkg::INFO_REF: status.info_value = st.ref_pos;
			smp_pkg::INFO_VIB: status.info_value = st.vib_acc;
			smp_pkg::INFO_DEV: status.info_value = st.dev_idx;
			default:           status.info_value = 32'h0;
		endcase
	end
endmodule : smp_top

// >>> dv/smp_props.sv
// port checker of the motion-profile positioner
// assumes it is bound onto smp_top, one clock domain
`timescale 1ns/1ps
module smp_props #(
	parameter int TICK_CYC = 20
) (
	input wire logic                 core_clk,
	input wire logic                 nrst,
	input wire logic                 positioner_mode,
	input wire smp_pkg::smp_params_s params,
	input wire smp_pkg::smp_cmd_s    cmd,
	input wire logic                 reserved_reference_enable,
	input wire logic                 servo_error_clear,
	input wire logic signed [15:0]   speed_ref,
	input wire smp_pkg::smp_status_s status
);
	// ****************
	// helpers
	// ****************
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic               man;
	logic signed [31:0] perr;
	logic [31:0]        aerr;
	int                 busy_cnt;
	assign man = !positioner_mode && reserved_reference_enable
		&& !cmd.test_profile_start && !cmd.wiring_test_cmd
		&& !status.wiring_test_active;
	assign perr = status.position_loop_reference
		- status.motor_position_steps;
	assign aerr = perr[31] ? -perr : perr;
	// a stuck calculation would stall every start, so bound it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			busy_cnt <= 0;
		else
			busy_cnt <= status.profile_calc_busy ? busy_cnt + 1 : 0;
	end
	property p_gate;
		!reserved_reference_enable |=> speed_ref == 16'sh0000;
	endproperty
	a_gate: assert property (p_gate) else $error("speed not gated");
	property p_fwd;
		(man && cmd.manual_fwd_or_feedback_select
			&& !cmd.manual_rev_or_incr_clear)[*3] |=> speed_ref
			== $signed($past(params.manual_speed_or_pulse_k_factor));
	endproperty
	a_fwd: assert property (p_fwd) else $error("manual fwd wrong");
	property p_rev;
		(man && cmd.manual_rev_or_incr_clear
			&& !cmd.manual_fwd_or_feedback_select)[*3] |=> speed_ref
			== -$signed($past(params.manual_speed_or_pulse_k_factor));
	endproperty
	a_rev: assert property (p_rev) else $error("manual rev wrong");
	property p_stop;
		$fell(status.profile_running) |->
			status.position_loop_reference == status.final_position;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not exact");
	property p_serr;
		positioner_mode && aerr > {16'h0000,
			params.info_value_or_error_window} |=> status.servo_error;
	endproperty
	a_serr: assert property (p_serr) else $error("servo flag missed");
	property p_sticky;
		status.servo_error && !servo_error_clear |=> status.servo_error;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
	property p_calc;
		$rose(cmd.position_start_cmd) && positioner_mode
			&& !status.profile_running |=> status.profile_calc_busy;
	endproperty
	a_calc: assert property (p_calc) else $error("no calculation");
	property p_calc_len;
		busy_cnt <= TICK_CYC + 1;
	endproperty
	a_calc_len: assert property (p_calc_len) else $error("calc too long");
	property p_info;
		!positioner_mode && params.info_select_or_position_gain
			== 16'h0001 |-> status.info_value
			== status.motor_position_steps;
	endproperty
	a_info: assert property (p_info) else $error("info wrong");
	property p_iclr;
		positioner_mode && cmd.manual_rev_or_incr_clear |=>
			status.incremental_position == 32'h00000000;
	endproperty
	a_iclr: assert property (p_iclr) else $error("incr not cleared");
	property p_rst1;
		$rose(cmd.reset_kind_one) && positioner_mode
			&& !status.profile_running && !status.profile_calc_busy
			|=> status.position_loop_reference == 32'h00000000;
	endproperty
	a_rst1: assert property (p_rst1) else $error("reset one failed");
endmodule : smp_props
bind smp_top smp_props #(.TICK_CYC(TICK_CYC)) u_smp_props (
	.core_clk(core_clk), .nrst(nrst), .positioner_mode(positioner_mode),
	.params(params), .cmd(cmd),
	.reserved_reference_enable(reserved_reference_enable),
	.servo_error_clear(servo_error_clear), .speed_ref(speed_ref),
	.status(status));

// >>> dv/smp_motor.sv
// motor with resolver and encoder, integrating the speed reference
// assumes one profile tick lasts TICK_CYC core clocks
`timescale 1ns/1ps
module smp_motor #(
	parameter int TICK_CYC = 20
) (
	input  wire logic               core_clk,
	input  wire logic signed [15:0] speed_ref,
	output logic [11:0]             resolver_angle,
	output logic                    encoder_step,
	output logic                    encoder_dir
);
	// ****************
	// shaft
	// ****************
	// integer rate: the shaft lags a little
	localparam int VPC = 32'h0000117a / TICK_CYC;
	logic signed [47:0] acc = '0;
	logic signed [31:0] enc = '0;
	wire  signed [31:0] pos = acc[47:16];
	assign resolver_angle = pos[11:0];
	always_ff @(posedge core_clk) begin
		acc <= acc + 48'(speed_ref * VPC);
		encoder_step <= enc != pos;
		encoder_dir <= pos < enc;
		if (enc != pos)
			enc <= (pos < enc) ? enc - 1 : enc + 1;
	end
endmodule : smp_motor

// >>> dv/testbench.sv
// self-checking bench of the motion-profile positioner
// assumes a 25 MHz clock and a shortened profile tick
`timescale 1ns/1ps
module testbench;
	// ****************
	// set-up
	// ****************
	localparam int TICK = 20;
	typedef struct {logic [2:0] b; logic [15:0] sp; logic [15:0] ex;} smp_row_s;
	logic core_clk = 1'h0;
	logic nrst, mode, ref_en, sw_en, hw_en, nz, se_clr, vib_clr, wr_en, fin;
	smp_pkg::smp_params_s par;
	smp_pkg::smp_cmd_s    cmd;
	smp_pkg::smp_status_s st;
	logic [31:0]          wr_data;
	logic [11:0]          ang;
	logic signed [15:0]   spd;
	logic                 estep, edir;
	int                   error_cnt = 0;
	int                   check_count = 0;
	smp_row_s rows [5] = '{'{3'h6, 16'h0064, 16'h0064},
		'{3'h5, 16'h0064, 16'hff9c}, '{3'h2, 16'h0064, 16'h0000},
		'{3'h5, 16'h00fa, 16'hff06}, '{3'h6, 16'h00fa, 16'h00fa}};
	always #20 core_clk = ~core_clk;
	smp_top #(.TICK_CYC(TICK)) u_smp_top (.core_clk(core_clk), .nrst(nrst),
		.positioner_mode(mode), .params(par), .cmd(cmd),
		.reserved_reference_enable(ref_en), .software_drive_enable(sw_en),
		.hardware_drive_enable(hw_en), .feedback_setting_nonzero(nz),
		.servo_error_clear(se_clr), .vibration_clear(vib_clr),
		.incr_wr_en(wr_en), .incr_wr_data(wr_data),
		.frequency_input_connector(fin), .resolver_angle(ang),
		.encoder_step(estep), .encoder_dir(edir), .speed_ref(spd),
		.status(st));
	smp_motor #(.TICK_CYC(TICK)) u_smp_motor (.core_clk(core_clk),
		.speed_ref(spd), .resolver_angle(ang), .encoder_step(estep),
		.encoder_dir(edir));
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic wait_move();
		int n;
		for (n = 0; n < 200 && st.profile_running !== 1'h1; n++)
			cyc(1);
		chk_val(32'(st.profile_running), 32'h1);
		for (n = 0; n < 30000 && st.profile_running !== 1'h0; n++)
			cyc(1);
		chk_val(32'(st.profile_running), 32'h0);
	endtask : wait_move
	task automatic move(input logic [31:0] inc, input logic dir,
		input logic [31:0] dest);
		wr_en = 1'h1;
		wr_data = inc;
		cyc(1);
		wr_en = 1'h0;
		cmd.move_direction = dir;
		cmd.position_start_cmd = 1'h1;
		cyc(2);
		cmd.position_start_cmd = 1'h0;
		wait_move();
		chk_val(st.final_position, dest);
		chk_val(st.position_loop_reference, dest);
	endtask : move
	task automatic wt(input logic sw, input logic nzv, input int hold,
		input logic [7:0] code);
		sw_en = sw;
		nz = nzv;
		cmd.wiring_test_cmd = 1'h1;
		cyc(hold);
		cmd.wiring_test_cmd = 1'h0;
		cyc(4);
		chk_val(st.info_value, 32'(code));
	endtask : wt
	initial begin
		repeat (60000) @(posedge core_clk);
		error_cnt++;
		give_verdict();
	end
	// ****************
	// sequence
	// ****************
	initial begin
		{nrst, mode, sw_en, nz, se_clr, vib_clr, wr_en, fin} = '0;
		{ref_en, hw_en} = 2'h3;
		par = smp_pkg::PARAM_DEFAULTS;
		cmd = '0;
		wr_data = '0;
		cyc(10);
		chk_val(32'(spd), 32'h0);
		chk_val(32'(st.profile_running), 32'h0);
		nrst = 1'h1;
		cyc(4);
		foreach (rows[i]) begin
			{ref_en, cmd.manual_fwd_or_feedback_select,
				cmd.manual_rev_or_incr_clear} = rows[i].b;
			par.manual_speed_or_pulse_k_factor = rows[i].sp;
			cyc(4);
			chk_val(32'(spd), {{16{rows[i].ex[15]}}, rows[i].ex});
		end
		cmd = '0;
		ref_en = 1'h1;
		wt(1'h1, 1'h0, 4, 8'h01);
		wt(1'h0, 1'h1, 4, 8'h05);
		wt(1'h0, 1'h0, 10, 8'h63);
		nz = 1'h0;
		vib_clr = 1'h1;
		cyc(2);
		chk_val(st.vibration_accumulator, 32'h0);
		vib_clr = 1'h0;
		mode = 1'h1;
		par.profile_speed_or_accel_time = 16'h0064;
		par.stroke_or_steady_speed = 16'h03e8;
		par.info_select_or_position_gain = 16'h0064;
		par.info_value_or_error_window = 16'h0000;
		par.manual_speed_or_pulse_k_factor = 16'h0003;
		cmd.reset_kind_one = 1'h1;
		cmd.pulse_input_enable = 1'h1;
		cmd.manual_rev_or_incr_clear = 1'h1;
		cyc(2);
		cmd = '0;
		cmd.pulse_input_enable = 1'h1;
		chk_val(st.position_loop_reference, 32'h0);
		chk_val(st.incremental_position, 32'h0);
		repeat (5) begin
			fin = 1'h1;
			cyc(3);
			fin = 1'h0;
			cyc(3);
		end
		cyc(4);
		chk_val(st.incremental_position, 32'h0000000f);
		cmd.pulse_input_enable = 1'h0;
		move(32'h00000258, 1'h0, 32'h00000258);
		move(32'hfffffda8, 1'h1, 32'h00000000);
		chk_val(32'(st.servo_error), 32'h1);
		par.info_value_or_error_window = 16'hffff;
		se_clr = 1'h1;
		cyc(1);
		se_clr = 1'h0;
		cyc(2);
		chk_val(32'(st.servo_error), 32'h0);
		wr_en = 1'h1;
		wr_data = 32'h0000012c;
		cyc(1);
		wr_en = 1'h0;
		cmd.move_direction = 1'h0;
		cmd.profile_calc_cmd = 1'h1;
		cyc(2);
		cmd.profile_calc_cmd = 1'h0;
		cyc(TICK + 4);
		chk_val(32'(st.profile_calc_busy), 32'h0);
		for (int r = 1; r <= 2; r++) begin
			cmd.run_precomputed_profile = 1'h1;
			cyc(2);
			cmd.run_precomputed_profile = 1'h0;
			cyc(TICK + 4);
			cmd.reset_kind_one = 1'h1;
			cyc(2);
			cmd.reset_kind_one = 1'h0;
			wait_move();
			chk_val(st.position_loop_reference, 32'(r * 300));
		end
		give_verdict();
	end
endmodule : testbench
